// file: core/cmbsc_master.v
// bus master controller driving a core memory slave through its pins
// assumes slave_sync, power_fail_n and the data lines arrive asynchronously
//
// Summary of operation
// - mode 00: word read, memory restores, byte select ignored.
// - after read-pause the next transaction is a write to the same address.
// - mode 11, byte select 1: high byte driven on lines 15..8.
// - mode 11, byte select 0: low byte driven on lines 7..0.
// - cycle starts on power good, idle slave sync, and a legal pause state, then master sync.
`timescale 1ns/1ns
`default_nettype none

module cmbsc_master
(
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_b,
    // user request
    input  wire        reqStart,
    input  wire [1:0]  reqMode,
    input  wire [17:0] reqAddr,
    input  wire [15:0] reqWrData,
    input  wire        reqInit,
    output reg         reqBusy,
    output reg         reqDone,
    output reg         reqTimeout,
    output reg         reqRefused,
    output reg  [15:0] reqRdData,
    output reg         pauseOpen,
    // memory pins
    output reg  [17:0] busAddr,
    output reg         modeCtlHi,
    output reg         modeCtlLo,
    output reg         masterSync_n,
    output reg         busInit_n,
    input  wire        slaveSync,
    input  wire        powerFail_n,
    input  wire [15:0] dataIn,
    output reg  [15:0] dataOut,
    output reg  [15:0] dataOe
);

`include "cmbsc_consts.vh"

localparam [4:0] ST_IDLE  = 5'h01;
localparam [4:0] ST_SETUP = 5'h02;
localparam [4:0] ST_WAITS = 5'h04;
localparam [4:0] ST_RELS  = 5'h08;
localparam [4:0] ST_INIT  = 5'h10;

localparam [7:0] SETUP_CYC = `CMBSC_SETUP_CYC;
localparam [7:0] INIT_CYC  = `CMBSC_INIT_CYC;
localparam [7:0] TMO_CYC   = `CMBSC_TIMEOUT_CYC;

wire        slaveSyncS;
wire        powerOkS;
wire [15:0] dataInS;
reg  [4:0]  state_reg;
reg  [7:0]  count_reg;
reg  [17:0] pauseAddr_reg;
reg         isRead_reg;

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
cmbsc_sync2 uSyncSsyn
(
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pinIn    (slaveSync),
    .levelOut (slaveSyncS)
);

cmbsc_sync2 uSyncPwr
(
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pinIn    (powerFail_n),
    .levelOut (powerOkS)
);

// data lines, one synchroniser per bit
genvar gi;
generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : gData
        cmbsc_sync2 uSyncD
        (
            .clk_sys  (clk_sys),
            .rst_b    (rst_b),
            .pinIn    (dataIn[gi]),
            .levelOut (dataInS[gi])
        );
    end
endgenerate

// legal request: after a read-pause only a write to the same address
wire pauseOk = !pauseOpen ||
               ((reqMode[1] == 1'b1) && (reqAddr == pauseAddr_reg));

// ----------------------------------------------------------------
// transaction sequencer
// ----------------------------------------------------------------
always @(posedge clk_sys or negedge rst_b)
begin
    if (!rst_b)
    begin
        state_reg     <= ST_IDLE;
        count_reg     <= 8'h00;
        pauseAddr_reg <= 18'h00000;
        isRead_reg    <= 1'b0;
        reqBusy       <= 1'b0;
        reqDone       <= 1'b0;
        reqTimeout    <= 1'b0;
        reqRefused    <= 1'b0;
        reqRdData     <= 16'h0000;
        pauseOpen     <= 1'b0;
        busAddr       <= 18'h00000;
        modeCtlHi     <= 1'b0;
        modeCtlLo     <= 1'b0;
        masterSync_n  <= 1'b1;
        busInit_n     <= 1'b1;
        dataOut       <= 16'h0000;
        dataOe        <= 16'h0000;
    end
    else
    begin
        reqDone    <= 1'b0;
        reqTimeout <= 1'b0;
        reqRefused <= 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (reqInit)
                begin
                    // initialise clears memory control state
                    busInit_n <= 1'b0;
                    pauseOpen <= 1'b0;
                    count_reg <= INIT_CYC;
                    reqBusy   <= 1'b1;
                    state_reg <= ST_INIT;
                end
                else if (reqStart)
                begin
                    // refuse while power fails, slave still busy, or pause broken
                    if (!powerOkS || slaveSyncS || !pauseOk)
                        reqRefused <= 1'b1;
                    else
                    begin
                        busAddr    <= reqAddr;
                        modeCtlHi  <= reqMode[1];
                        modeCtlLo  <= reqMode[0];
                        isRead_reg <= !reqMode[1];
                        case (reqMode)
                            `CMBSC_MODE_WORD_WRITE:
                            begin
                                dataOut <= reqWrData;
                                dataOe  <= 16'hFFFF;
                            end
                            `CMBSC_MODE_BYTE_WRITE:
                            begin
                                dataOut <= reqWrData;
                                if (reqAddr[0])
                                    dataOe <= 16'hFF00;
                                else
                                    dataOe <= 16'h00FF;
                            end
                            default:
                                dataOe <= 16'h0000;
                        endcase
                        if (reqMode == `CMBSC_MODE_READ_PAUSE)
                        begin
                            pauseOpen     <= 1'b1;
                            pauseAddr_reg <= reqAddr;
                        end
                        else
                            pauseOpen <= 1'b0;
                        count_reg <= SETUP_CYC;
                        reqBusy   <= 1'b1;
                        state_reg <= ST_SETUP;
                    end
                end
            end
            ST_SETUP:
            begin
                // address and mode settle before master sync
                if (count_reg == 8'h00)
                begin
                    masterSync_n <= 1'b0;
                    count_reg    <= TMO_CYC;
                    state_reg    <= ST_WAITS;
                end
                else
                    count_reg <= count_reg - 8'h01;
            end
            ST_WAITS:
            begin
                // wait for slave sync, then capture read data
                if (slaveSyncS)
                begin
                    if (isRead_reg)
                        reqRdData <= dataInS;
                    masterSync_n <= 1'b1;
                    count_reg    <= TMO_CYC;
                    state_reg    <= ST_RELS;
                end
                else if (count_reg == 8'h00)
                begin
                    masterSync_n <= 1'b1;
                    reqTimeout   <= 1'b1;
                    pauseOpen    <= 1'b0;
                    dataOe       <= 16'h0000;
                    reqBusy      <= 1'b0;
                    state_reg    <= ST_IDLE;
                end
                else
                    count_reg <= count_reg - 8'h01;
            end
            ST_RELS:
            begin
                // slave drops its sync after master releases
                if (!slaveSyncS || count_reg == 8'h00)
                begin
                    dataOe     <= 16'h0000;
                    reqDone    <= slaveSyncS ? 1'b0 : 1'b1;
                    reqTimeout <= slaveSyncS ? 1'b1 : 1'b0;
                    reqBusy    <= 1'b0;
                    state_reg  <= ST_IDLE;
                end
                else
                    count_reg <= count_reg - 8'h01;
            end
            ST_INIT:
            begin
                if (count_reg == 8'h00)
                begin
                    busInit_n <= 1'b1;
                    reqBusy   <= 1'b0;
                    reqDone   <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                else
                    count_reg <= count_reg - 8'h01;
            end
            default:
            begin
                state_reg <= ST_IDLE;
            end
        endcase
    end
end

endmodule

`default_nettype wire

// file: core/cmbsc_sync2.v
// two-flop synchroniser for one pin level
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none

module cmbsc_sync2
(
    // clock and reset
    input  wire clk_sys,
    input  wire rst_b,
    // level
    input  wire pinIn,
    output wire levelOut
);

reg stage1_reg;
reg stage2_reg;

// ----------------------------------------------------------------
// double flop, first stage read only by the second
// ----------------------------------------------------------------
always @(posedge clk_sys or negedge rst_b)
begin
    if (!rst_b)
    begin
        stage1_reg <= 1'b0;
        stage2_reg <= 1'b0;
    end
    else
    begin
        stage1_reg <= pinIn;
        stage2_reg <= stage1_reg;
    end
end

assign levelOut = stage2_reg;

endmodule

`default_nettype wire

// file: inc/cmbsc_consts.vh
// constants for the core memory bus master controller
// assumes a 25 MHz system clock; included by bare name
`ifndef CMBSC_CONSTS_VH
`define CMBSC_CONSTS_VH

// ----------------------------------------------------------------
// transaction codes on the mode-control pair
// ----------------------------------------------------------------
`define CMBSC_MODE_READ_RESTORE 2'h0
`define CMBSC_MODE_READ_PAUSE   2'h1
`define CMBSC_MODE_WORD_WRITE   2'h2
`define CMBSC_MODE_BYTE_WRITE   2'h3

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define CMBSC_DATA_W     16
`define CMBSC_ADDR_W     18
`define CMBSC_HI_BYTE_MSB 15
`define CMBSC_HI_BYTE_LSB 8
`define CMBSC_LO_BYTE_MSB 7
`define CMBSC_LO_BYTE_LSB 0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CMBSC_CLK_NS          40
`define CMBSC_SETUP_NS        150
`define CMBSC_SETUP_CYC       8'h04 // 150 ns rounded up to whole clocks
`define CMBSC_INIT_NS         200
`define CMBSC_INIT_CYC        8'h05 // 200 ns in whole clocks
`define CMBSC_TIMEOUT_CYC     8'hFF
`define CMBSC_CNT_W           8

`endif

// file: verification/cmbsc_master_checker.sv
// checker for the pins and user flags of the bus master controller
// assumes one clock domain and an active low asynchronous reset
`timescale 1ns/1ns
`default_nettype none

module cmbsc_master_checker
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // user side
    input wire logic        reqStart,
    input wire logic        reqInit,
    input wire logic        reqBusy,
    input wire logic        reqDone,
    input wire logic        reqRefused,
    // memory pins
    input wire logic [17:0] busAddr,
    input wire logic        modeCtlHi,
    input wire logic        modeCtlLo,
    input wire logic        masterSync_n,
    input wire logic        busInit_n,
    input wire logic        slaveSync,
    input wire logic        powerFail_n,
    input wire logic [15:0] dataOe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // data lane drive per transaction
    // ----------------------------------------
    read_float_a: assert property (!masterSync_n && !modeCtlHi |-> dataOe == 16'h0000)
        else $error("data lines driven during a read");
    word_drive_a: assert property (!masterSync_n && modeCtlHi && !modeCtlLo |-> dataOe == 16'hFFFF)
        else $error("word write not driving all lanes");
    byte_hi_a: assert property (!masterSync_n && modeCtlHi && modeCtlLo && busAddr[0] |-> dataOe == 16'hFF00)
        else $error("high byte write lanes wrong");
    byte_lo_a: assert property (!masterSync_n && modeCtlHi && modeCtlLo && !busAddr[0] |-> dataOe == 16'h00FF)
        else $error("low byte write lanes wrong");
    // ----------------------------------------
    // handshake and initialise
    // ----------------------------------------
    start_gate_a: assert property ($fell(masterSync_n) |-> !$past(slaveSync) && $past(reqBusy, 4) && busInit_n)
        else $error("master sync without setup or with slave sync up");
    pins_stand_a: assert property (!masterSync_n |-> $stable(busAddr) && $stable(dataOe) && $stable(modeCtlHi))
        else $error("bus pins moved during master sync");
    sync_drop_a: assert property (!masterSync_n && slaveSync |-> ##[1:5] masterSync_n)
        else $error("master sync not released after slave sync");
    done_clean_a: assert property (reqDone |-> !reqBusy && masterSync_n && dataOe == 16'h0000)
        else $error("done while bus still held");
    init_len_a: assert property ($fell(busInit_n) |-> !busInit_n [*6] ##1 busInit_n)
        else $error("initialise pulse length wrong");
    init_quiet_a: assert property (!busInit_n |-> masterSync_n && dataOe == 16'h0000)
        else $error("transfer during initialise");
    pf_refuse_a: assert property (reqStart && !reqInit && !reqBusy && !powerFail_n && !$past(powerFail_n, 3)
        |=> reqRefused)
        else $error("start not refused in power fail");
endmodule

bind cmbsc_master cmbsc_master_checker i_chk (.clk_sys, .rst_b, .reqStart, .reqInit, .reqBusy, .reqDone,
    .reqRefused, .busAddr, .modeCtlHi, .modeCtlLo, .masterSync_n, .busInit_n, .slaveSync, .powerFail_n, .dataOe);

`default_nettype wire

// file: verification/cmbsc_master_tb.sv
// self-checking bench for the bus master controller
// assumes the memory model and checker are compiled first
`timescale 1ns/1ns
`default_nettype none

module cmbsc_master_tb;
    logic        clk_sys, rst_b, reqStart, reqInit, reqBusy, reqDone, reqTimeout, reqRefused, pauseOpen;
    logic        modeCtlHi, modeCtlLo, masterSync_n, busInit_n, slaveSync, powerFail_n, readOnly;
    logic [1:0]  reqMode, res;
    logic [17:0] reqAddr, busAddr;
    logic [15:0] reqWrData, reqRdData, dataIn, dataOut, dataOe, respNs;
    int          fail_count, n_tests;
    // ----------------------------------------
    // design and memory
    // ----------------------------------------
    cmbsc_master i_dut (.clk_sys, .rst_b, .reqStart, .reqMode, .reqAddr, .reqWrData, .reqInit, .reqBusy,
        .reqDone, .reqTimeout, .reqRefused, .reqRdData, .pauseOpen, .busAddr, .modeCtlHi, .modeCtlLo,
        .masterSync_n, .busInit_n, .slaveSync, .powerFail_n, .dataIn, .dataOut, .dataOe);
    cmbsc_mem_model i_mem (.busAddr, .modeCtlHi, .modeCtlLo, .masterSync_n, .busInit_n, .powerFail_n,
        .dataOut, .dataOe, .slaveSync, .dataIn, .readOnly, .respNs);
    // 25 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask
    // one request, wait for its outcome, compare it
    task automatic op(input logic ini, input logic [1:0] m, input logic [17:0] a, input logic [15:0] d,
        input logic [1:0] er);
        int i;
        reqInit = ini;
        reqStart = !ini;
        reqMode = m;
        reqAddr = a;
        reqWrData = d;
        res = 2'h3;
        @(negedge clk_sys);
        reqInit = 1'b0;
        reqStart = 1'b0;
        // a refusal pulse already stands at this edge, so look before waiting
        for (i = 0; i < 400 && res === 2'h3; i++)
        begin
            if (reqDone === 1'b1) res = 2'h0;
            else if (reqTimeout === 1'b1) res = 2'h1;
            else if (reqRefused === 1'b1) res = 2'h2;
            @(negedge clk_sys);
        end
        chk("outcome", {14'h0000, er}, {14'h0000, res});
        chk("reqBusy", 16'h0000, {15'h0000, reqBusy});
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #(40 * 6000);
        fail_count++;
        test_done;
    end
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        {fail_count, n_tests, reqStart, reqInit, reqMode, reqAddr, reqWrData, readOnly} = '0;
        powerFail_n = 1'b1;
        respNs = 16'h0064;
        rst_b = 1'b0;
        repeat (12) @(negedge clk_sys);
        rst_b = 1'b1;
        @(negedge clk_sys);
        op(1, 2'h0, 18'h00000, 16'h0000, 2'h0);
        op(0, 2'h2, 18'h00002, 16'h1234, 2'h0);
        op(0, 2'h0, 18'h00002, 16'h0000, 2'h0);
        op(0, 2'h0, 18'h00003, 16'h0000, 2'h0);
        chk("rdData", 16'h1234, reqRdData);
        op(0, 2'h3, 18'h00003, 16'hAB99, 2'h0);
        op(0, 2'h3, 18'h00002, 16'h77CD, 2'h0);
        op(0, 2'h1, 18'h00002, 16'h0000, 2'h0);
        chk("rdData", 16'hABCD, reqRdData);
        chk("pauseOpen", 16'h0001, {15'h0000, pauseOpen});
        op(0, 2'h0, 18'h00002, 16'h0000, 2'h2);
        op(0, 2'h2, 18'h00004, 16'h1111, 2'h2);
        op(0, 2'h2, 18'h00002, 16'h5555, 2'h0);
        chk("pauseOpen", 16'h0000, {15'h0000, pauseOpen});
        readOnly = 1'b1;
        op(0, 2'h2, 18'h00002, 16'h9999, 2'h0);
        readOnly = 1'b0;
        respNs = 16'h07D0;
        op(0, 2'h0, 18'h00002, 16'h0000, 2'h0);
        chk("rdData", 16'h5555, reqRdData);
        op(0, 2'h1, 18'h00002, 16'h0000, 2'h0);
        op(1, 2'h0, 18'h00000, 16'h0000, 2'h0);
        chk("pauseOpen", 16'h0000, {15'h0000, pauseOpen});
        op(0, 2'h0, 18'h00004, 16'h0000, 2'h0);
        powerFail_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        op(0, 2'h0, 18'h00002, 16'h0000, 2'h2);
        powerFail_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        respNs = 16'h2EE0;
        op(0, 2'h0, 18'h00002, 16'h0000, 2'h1);
        repeat (300) @(negedge clk_sys);
        test_done;
    end
endmodule

`default_nettype wire

// file: verification/cmbsc_mem_model.sv
// behavioural core memory answering the master's pins
// assumes 256 words suffice; no clock, timing by delays
`timescale 1ns/1ns
`default_nettype none

module cmbsc_mem_model
(
    // bus pins
    input  wire logic [17:0] busAddr,
    input  wire logic        modeCtlHi,
    input  wire logic        modeCtlLo,
    input  wire logic        masterSync_n,
    input  wire logic        busInit_n,
    input  wire logic        powerFail_n,
    input  wire logic [15:0] dataOut,
    input  wire logic [15:0] dataOe,
    output var  logic        slaveSync,
    output var  logic [15:0] dataIn,
    // bench controls
    input  wire logic        readOnly,
    input  wire logic [15:0] respNs
);
    logic [15:0] mem [0:255];
    logic [15:0] wd;
    logic [1:0]  md;
    logic        pause;
    // ----------------------------------------
    // bus transaction
    // ----------------------------------------
    initial
    begin
        slaveSync = 1'b0;
        dataIn = 16'h5A5A;
        pause = 1'b0;
    end
    // initialise clears the pause state
    always @(negedge busInit_n) pause = 1'b0;
    // decode, move data, then full handshake
    always @(negedge masterSync_n)
    begin
        if (powerFail_n && busInit_n && !slaveSync)
        begin
            #(respNs);
            md = readOnly ? 2'h0 : {modeCtlHi, modeCtlLo};
            wd = dataOut & dataOe;
            if (!md[1])
                dataIn = mem[busAddr[8:1]];
            else if (!md[0])
                mem[busAddr[8:1]] = wd;
            else if (busAddr[0])
                mem[busAddr[8:1]][15:8] = wd[15:8];
            else
                mem[busAddr[8:1]][7:0] = wd[7:0];
            pause = (md == 2'h1);
            slaveSync = 1'b1;
            wait (masterSync_n);
            #20 slaveSync = 1'b0;
            dataIn = ~dataIn; // released lines do not keep old data
        end
    end
endmodule

`default_nettype wire
